// >>> hdl/uied_pkg.sv
package uied_pkg;

   // register byte offsets on the lite bus
   localparam logic [7:0] OFS_FIRST_BASE   = 8'h00;
   localparam logic [7:0] OFS_SECOND_BASE  = 8'h04;
   localparam logic [7:0] OFS_FIRST_COUNT  = 8'h08;
   localparam logic [7:0] OFS_SECOND_COUNT = 8'h0c;
   localparam logic [7:0] OFS_BUF_SIZE     = 8'h10;
   localparam logic [7:0] OFS_CONFIG       = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h1c;
   localparam logic [7:0] OFS_STATE        = 8'h20;

   // field positions
   localparam int EMPTY_BIT      = 7;
   localparam int IRQ_SENT_FIRST = 0;
   localparam int IRQ_SENT_SECOND = 1;
   localparam int IRQ_NAK        = 2;
   localparam int IRQ_W          = 3;
   localparam int STATE_SEL_BIT  = 0;
   localparam int STATE_PEND_BIT = 1;

   // values after reset
   localparam logic [7:0]       RST_BASE  = 8'h00;
   localparam logic [7:0]       RST_COUNT = 8'h80;
   localparam logic [7:0]       RST_SIZE  = 8'h00;
   localparam logic [7:0]       RST_CFG   = 8'h00;
   localparam logic [IRQ_W-1:0] RST_MASK  = 3'h0;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      UIED_ANS_NONE,
      UIED_ANS_DATA,
      UIED_ANS_NAK
   } uied_ans_kind_t;

   typedef struct packed {
      logic       enable;
      logic       iso;
      logic       double_buffer_select;
      logic [4:0] sample_size;
   } uied_cfg_t;

   typedef struct packed {
      logic       empty;
      logic [6:0] count;
   } uied_count_t;

   typedef struct packed {
      uied_ans_kind_t kind;
      logic           from_second;
      logic [10:0]    addr;
      logic [11:0]    len;
      logic [10:0]    area;
   } uied_answer_t;

endpackage : uied_pkg

// >>> hdl/uied_top.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
module uied_top (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  in_token,
   input  wire logic                  in_done,
   output logic                       ans_valid,
   output uied_pkg::uied_answer_t     answer,
   output logic                       irq
);
   import uied_pkg::*;

   logic [7:0]       first_base_ff;
   logic [7:0]       second_base_ff;
   logic [7:0]       size_ff;
   uied_count_t      first_cnt_ff;
   uied_count_t      second_cnt_ff;
   uied_cfg_t        cfg_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] nxt_irq_stat;
   logic [IRQ_W-1:0] irq_event;
   logic             irq_ff;
   logic             cur_sel_ff;
   logic             pend_ff;
   logic             pend_sel_ff;
   logic [11:0]      pend_len_ff;
   logic [10:0]      iso_rd_ff;
   logic [11:0]      nxt_iso_rd;
   logic             ans_valid_ff;
   uied_answer_t     ans_ff;
   uied_answer_t     nxt_ans;

   logic             awready_ff;
   logic             wready_ff;
   logic             bvalid_ff;
   logic [1:0]       bresp_ff;
   logic             arready_ff;
   logic             rvalid_ff;
   logic [1:0]       rresp_ff;
   logic [31:0]      rdata_ff;
   logic [7:0]       wr_addr_ff;
   logic [7:0]       wr_data_ff;
   logic             wr_lane_ff;
   logic             wr_fire;
   logic             done_ok;
   logic             sel_second;
   uied_count_t      sel_cnt;
   logic [12:0]      iso_bytes;
   logic [31:0]      nxt_rdata;
   logic             rd_hit;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == OFS_FIRST_BASE || a == OFS_SECOND_BASE || a == OFS_FIRST_COUNT ||
             a == OFS_SECOND_COUNT || a == OFS_BUF_SIZE || a == OFS_CONFIG ||
             a == OFS_IRQ_STATUS || a == OFS_IRQ_MASK || a == OFS_STATE;
   endfunction : is_mapped

   // write: address and data taken in either order, one write at a time
   assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= AXI_OKAY;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
         wr_lane_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            wr_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_ff) begin
            wready_ff  <= 1'b0;
            wr_data_ff <= s_axi_wdata[7:0];
            wr_lane_ff <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= is_mapped(wr_addr_ff) ? AXI_OKAY : AXI_SLVERR;
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // only byte lane 0 carries register bits; upper lanes are ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_base_ff  <= RST_BASE;
         second_base_ff <= RST_BASE;
         size_ff        <= RST_SIZE;
         cfg_ff         <= RST_CFG;
         irq_mask_ff    <= RST_MASK;
      end else if (wr_fire && wr_lane_ff) begin
         case (wr_addr_ff)
            OFS_FIRST_BASE:  first_base_ff  <= wr_data_ff;
            OFS_SECOND_BASE: second_base_ff <= wr_data_ff;
            OFS_BUF_SIZE:    size_ff        <= wr_data_ff;
            OFS_CONFIG:      cfg_ff         <= wr_data_ff;
            OFS_IRQ_MASK:    irq_mask_ff    <= wr_data_ff[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // hardware set of the empty flag wins over a software write in the same cycle
   assign done_ok = in_done && pend_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_cnt_ff  <= RST_COUNT;
         second_cnt_ff <= RST_COUNT;
      end else begin
         if (wr_fire && wr_lane_ff && wr_addr_ff == OFS_FIRST_COUNT) begin
            first_cnt_ff <= wr_data_ff;
         end
         if (wr_fire && wr_lane_ff && wr_addr_ff == OFS_SECOND_COUNT) begin
            second_cnt_ff <= wr_data_ff;
         end
         if (done_ok && !pend_sel_ff) begin
            first_cnt_ff.empty <= 1'b1;
         end
         if (done_ok && pend_sel_ff) begin
            second_cnt_ff.empty <= 1'b1;
         end
      end
   end

   // read: one at a time, answer one cycle after the address is taken
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      rd_hit    = 1'b1;
      case (s_axi_araddr)
         OFS_FIRST_BASE:   nxt_rdata[7:0] = first_base_ff;
         OFS_SECOND_BASE:  nxt_rdata[7:0] = second_base_ff;
         OFS_FIRST_COUNT:  nxt_rdata[7:0] = first_cnt_ff;
         OFS_SECOND_COUNT: nxt_rdata[7:0] = second_cnt_ff;
         OFS_BUF_SIZE:     nxt_rdata[7:0] = size_ff;
         OFS_CONFIG:       nxt_rdata[7:0] = cfg_ff;
         OFS_IRQ_STATUS:   nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
         OFS_IRQ_MASK:     nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
         OFS_STATE: begin
            nxt_rdata[STATE_SEL_BIT]  = cur_sel_ff;
            nxt_rdata[STATE_PEND_BIT] = pend_ff;
         end
         default:          rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= AXI_OKAY;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= rd_hit ? AXI_OKAY : AXI_SLVERR;
         end
         if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   // answer decision for an IN token
   assign sel_second = cfg_ff.double_buffer_select && !cfg_ff.iso && cur_sel_ff;
   assign sel_cnt    = sel_second ? second_cnt_ff : first_cnt_ff;
   assign iso_bytes  = sel_cnt.count * ({1'b0, cfg_ff.sample_size} + 6'h01);

   always_comb begin
      nxt_ans             = ans_ff;
      nxt_ans.from_second = sel_second;
      nxt_ans.area        = {size_ff, 3'h0};
      if (!cfg_ff.enable) begin
         nxt_ans.kind = UIED_ANS_NONE;
      end else if (cfg_ff.iso) begin
         nxt_ans.kind = UIED_ANS_DATA;
      end else if (sel_cnt.empty) begin
         nxt_ans.kind = UIED_ANS_NAK;
      end else begin
         nxt_ans.kind = UIED_ANS_DATA;
      end
      if (cfg_ff.iso) begin
         nxt_ans.len  = iso_bytes[11:0];
         nxt_ans.addr = {first_base_ff, 3'h0} + iso_rd_ff;
      end else begin
         nxt_ans.len  = {5'h00, sel_cnt.count};
         nxt_ans.addr = sel_second ? {second_base_ff, 3'h0} : {first_base_ff, 3'h0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ans_valid_ff <= 1'b0;
         ans_ff       <= '0;
      end else begin
         ans_valid_ff <= in_token;
         if (in_token) begin
            ans_ff <= nxt_ans;
         end
      end
   end

   // a packet stays pending until the host acknowledges it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_ff     <= 1'b0;
         pend_sel_ff <= 1'b0;
         pend_len_ff <= 12'h000;
      end else begin
         if (done_ok) begin
            pend_ff <= 1'b0;
         end
         if (in_token && nxt_ans.kind == UIED_ANS_DATA) begin
            pend_ff     <= 1'b1;
            pend_sel_ff <= sel_second;
            pend_len_ff <= nxt_ans.len;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_sel_ff <= 1'b0;
      end else if (!cfg_ff.double_buffer_select || cfg_ff.iso) begin
         cur_sel_ff <= 1'b0;
      end else if (done_ok) begin
         cur_sel_ff <= !pend_sel_ff;
      end
   end

   // circular read offset wraps once; a packet longer than the area is a software fault
   always_comb begin
      nxt_iso_rd = {1'b0, iso_rd_ff} + pend_len_ff;
      if (size_ff != 8'h00 && nxt_iso_rd >= {1'b0, size_ff, 3'h0}) begin
         nxt_iso_rd = nxt_iso_rd - {1'b0, size_ff, 3'h0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         iso_rd_ff <= 11'h000;
      end else if (!cfg_ff.iso) begin
         iso_rd_ff <= 11'h000;
      end else if (done_ok) begin
         iso_rd_ff <= nxt_iso_rd[10:0];
      end
   end

   // sticky status, write one to clear; a new event beats the clear
   always_comb begin
      irq_event                  = '0;
      irq_event[IRQ_SENT_FIRST]  = done_ok && !pend_sel_ff;
      irq_event[IRQ_SENT_SECOND] = done_ok && pend_sel_ff;
      irq_event[IRQ_NAK]         = in_token && nxt_ans.kind == UIED_ANS_NAK;
      nxt_irq_stat               = irq_stat_ff;
      if (wr_fire && wr_lane_ff && wr_addr_ff == OFS_IRQ_STATUS) begin
         nxt_irq_stat = nxt_irq_stat & ~wr_data_ff[IRQ_W-1:0];
      end
      nxt_irq_stat = nxt_irq_stat | irq_event;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= '0;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign ans_valid     = ans_valid_ff;
   assign answer        = ans_ff;
   assign irq           = irq_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_first_base;
      in_token && cfg_ff.enable && !cfg_ff.iso && !cfg_ff.double_buffer_select
         |=> answer.addr == {$past(first_base_ff), 3'h0};
   endproperty
   a_first_base: assert property (p_first_base) else $error("first buffer address wrong");

   property p_second_base;
      in_token && cfg_ff.enable && !cfg_ff.iso && cfg_ff.double_buffer_select && cur_sel_ff
         |=> answer.from_second && answer.addr[10:3] == $past(second_base_ff);
   endproperty
   a_second_base: assert property (p_second_base) else $error("second buffer address wrong");

   property p_aligned;
      ans_valid && !$past(cfg_ff.iso) |-> answer.addr[2:0] == 3'h0;
   endproperty
   a_aligned: assert property (p_aligned) else $error("buffer start not aligned");

   property p_empty_set;
      done_ok && !pend_sel_ff |=> first_cnt_ff.empty ##1 1'b1;
   endproperty
   a_empty_set: assert property (p_empty_set) else $error("empty flag not set after send");

   property p_nak;
      in_token && cfg_ff.enable && !cfg_ff.iso && !cfg_ff.double_buffer_select && first_cnt_ff.empty
         |=> ans_valid && answer.kind == UIED_ANS_NAK && irq_stat_ff[IRQ_NAK];
   endproperty
   a_nak: assert property (p_nak) else $error("empty buffer not answered with nak");

   property p_iso_data;
      in_token && cfg_ff.enable && cfg_ff.iso |=> answer.kind == UIED_ANS_DATA;
   endproperty
   a_iso_data: assert property (p_iso_data) else $error("isochronous endpoint refused data");

   property p_iso_len;
      in_token && cfg_ff.enable && cfg_ff.iso
         |=> answer.len == 12'($past(first_cnt_ff.count) * ($past(cfg_ff.sample_size) + 6'h01));
   endproperty
   a_iso_len: assert property (p_iso_len) else $error("sample count not scaled");

   property p_area;
      in_token |=> answer.area == {$past(size_ff), 3'h0};
   endproperty
   a_area: assert property (p_area) else $error("buffer area length wrong");

   property p_alternate;
      done_ok && cfg_ff.double_buffer_select && !cfg_ff.iso && !$changed(cfg_ff) |=> cur_sel_ff != $past(cur_sel_ff);
   endproperty
   a_alternate: assert property (p_alternate) else $error("buffers did not alternate");

   c_nak:    cover property (ans_valid && answer.kind == UIED_ANS_NAK);
   c_second: cover property (ans_valid && answer.kind == UIED_ANS_DATA && answer.from_second);
   c_iso:    cover property (done_ok && cfg_ff.iso && iso_rd_ff != 11'h000);
   c_irq:    cover property (irq);

endmodule : uied_top

// >>> testbench/uied_host_model.sv
module uied_host_model (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ans_valid,
   input  wire uied_pkg::uied_answer_t answer,
   output logic                        in_token,
   output logic                        in_done
);
   timeunit 1ns;
   timeprecision 1ps;
   import uied_pkg::*;

   initial begin
      in_token = 1'b0;
      in_done  = 1'b0;
   end

   // host acks only a delivered data packet; dly models a slow host
   task automatic transact(input logic ack, input int unsigned dly, output uied_answer_t got, output logic ok);
      ok  = 1'b0;
      got = '0;
      @(posedge clk);
      in_token <= 1'b1;
      @(posedge clk);
      in_token <= 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge clk);
         if (ans_valid === 1'b1) begin
            got = answer;
            ok  = 1'b1;
         end
      end
      if (ok && ack && got.kind === UIED_ANS_DATA) begin
         repeat (dly) @(posedge clk);
         in_done <= 1'b1;
         @(posedge clk);
         in_done <= 1'b0;
      end
      @(posedge clk);
   endtask : transact
endmodule : uied_host_model

// >>> testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import uied_pkg::*;

   logic         clk, rst_n;
   logic [7:0]   awaddr, araddr;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready;
   logic [31:0]  wdata, rdata;
   logic [3:0]   wstrb, wr_strb;
   logic [1:0]   bresp, rresp;
   logic         in_token, in_done, ans_valid, irq;
   uied_answer_t answer;
   int unsigned  err_total;
   int unsigned  checks;

   uied_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_token(in_token),
      .in_done(in_done), .ans_valid(ans_valid), .answer(answer), .irq(irq));

   uied_host_model host (.clk(clk), .rst_n(rst_n), .ans_valid(ans_valid), .answer(answer),
      .in_token(in_token), .in_done(in_done));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   task automatic timeout(input string what);
      err_total++;
      $display("BAD t=%0t no answer for %s", $time, what);
      finish_test();
   endtask : timeout

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp_resp);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h0, d};
      wstrb   <= wr_strb;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int i = 0; i < 20 && !done; i++) begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            chk(32'(bresp), 32'(exp_resp), "bresp");
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) timeout("write");
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp, input string what);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int i = 0; i < 20 && !done; i++) begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            chk(rdata, exp, what);
            chk(32'(rresp), 32'(exp_resp), what);
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) timeout(what);
   endtask : rd

   // answer fields other than kind only mean something for a data answer
   task automatic tok(input logic ack, input int unsigned dly, input uied_ans_kind_t k, input logic sec,
                      input logic [10:0] ad, input logic [11:0] ln);
      uied_answer_t g;
      logic         ok;
      host.transact(ack, dly, g, ok);
      if (!ok) begin
         timeout("token");
      end else begin
         chk(32'(g.kind), 32'(k), "kind");
         if (k == UIED_ANS_DATA) begin
            chk(32'(g.from_second), 32'(sec), "from_second");
            chk(32'(g.addr), 32'(ad), "addr");
            chk(32'(g.len), 32'(ln), "len");
            chk(32'(g.area), 32'd192, "area");
         end
      end
   endtask : tok

   initial begin
      err_total = 0;
      checks    = 0;
      rst_n     = 1'b0;
      awaddr    = 8'h00;
      awvalid   = 1'b0;
      wdata     = 32'h0;
      wstrb     = 4'h0;
      wr_strb   = 4'h1;
      wvalid    = 1'b0;
      bready    = 1'b0;
      araddr    = 8'h00;
      arvalid   = 1'b0;
      rready    = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_FIRST_BASE, 32'(RST_BASE), AXI_OKAY, "rst base1");
      rd(OFS_SECOND_BASE, 32'(RST_BASE), AXI_OKAY, "rst base2");
      rd(OFS_FIRST_COUNT, 32'(RST_COUNT), AXI_OKAY, "rst count1");
      rd(OFS_BUF_SIZE, 32'(RST_SIZE), AXI_OKAY, "rst size");
      rd(OFS_CONFIG, 32'(RST_CFG), AXI_OKAY, "rst cfg");
      rd(OFS_IRQ_MASK, 32'(RST_MASK), AXI_OKAY, "rst mask");
      rd(8'h24, 32'h0, AXI_SLVERR, "unmapped rd");
      wr(8'h28, 8'hff, AXI_SLVERR);
      tok(1'b1, 0, UIED_ANS_NONE, 1'b0, 11'h0, 12'h0);
      wr(OFS_FIRST_BASE, 8'h12, AXI_OKAY);
      wr(OFS_SECOND_BASE, 8'h34, AXI_OKAY);
      wr(OFS_BUF_SIZE, 8'h18, AXI_OKAY);
      rd(OFS_FIRST_BASE, 32'h12, AXI_OKAY, "base1");
      rd(OFS_SECOND_BASE, 32'h34, AXI_OKAY, "base2");
      rd(OFS_BUF_SIZE, 32'h18, AXI_OKAY, "size");
      // lane 0 strobe low: write acknowledged but ignored
      wr_strb = 4'h0;
      wr(OFS_FIRST_BASE, 8'hee, AXI_OKAY);
      wr_strb = 4'h1;
      rd(OFS_FIRST_BASE, 32'h12, AXI_OKAY, "strobe off");
      $display("test registers done");
      // single buffer: second buffer loaded but must stay unused
      wr(OFS_IRQ_MASK, 8'h07, AXI_OKAY);
      wr(OFS_SECOND_COUNT, 8'h02, AXI_OKAY);
      wr(OFS_FIRST_COUNT, 8'h05, AXI_OKAY);
      wr(OFS_CONFIG, 8'h80, AXI_OKAY);
      tok(1'b1, 5, UIED_ANS_DATA, 1'b0, {8'h12, 3'h0}, 12'd5);
      rd(OFS_FIRST_COUNT, 32'h85, AXI_OKAY, "empty set");
      chk(32'(irq), 32'h1, "irq sent");
      tok(1'b1, 0, UIED_ANS_NAK, 1'b0, 11'h0, 12'h0);
      tok(1'b1, 0, UIED_ANS_NAK, 1'b0, 11'h0, 12'h0);
      rd(OFS_IRQ_STATUS, 32'h05, AXI_OKAY, "status");
      wr(OFS_IRQ_STATUS, 8'h01, AXI_OKAY);
      rd(OFS_IRQ_STATUS, 32'h04, AXI_OKAY, "w1c");
      wr(OFS_IRQ_MASK, 8'h00, AXI_OKAY);
      // irq follows the new mask one edge after the write lands
      @(posedge clk);
      chk(32'(irq), 32'h0, "irq masked");
      wr(OFS_IRQ_MASK, 8'h07, AXI_OKAY);
      @(posedge clk);
      chk(32'(irq), 32'h1, "irq unmasked");
      wr(OFS_IRQ_STATUS, 8'h04, AXI_OKAY);
      chk(32'(irq), 32'h0, "irq cleared");
      $display("test single buffer done");
      wr(OFS_FIRST_COUNT, 8'h03, AXI_OKAY);
      wr(OFS_SECOND_COUNT, 8'h04, AXI_OKAY);
      wr(OFS_CONFIG, 8'ha0, AXI_OKAY);
      rd(OFS_STATE, 32'h0, AXI_OKAY, "state");
      tok(1'b1, 3, UIED_ANS_DATA, 1'b0, {8'h12, 3'h0}, 12'd3);
      tok(1'b1, 0, UIED_ANS_DATA, 1'b1, {8'h34, 3'h0}, 12'd4);
      tok(1'b1, 0, UIED_ANS_NAK, 1'b0, 11'h0, 12'h0);
      rd(OFS_SECOND_COUNT, 32'h84, AXI_OKAY, "empty2");
      $display("test double buffer done");
      // iso with the empty flag left set: must still send
      wr(OFS_IRQ_STATUS, 8'h07, AXI_OKAY);
      wr(OFS_FIRST_COUNT, 8'h85, AXI_OKAY);
      wr(OFS_CONFIG, 8'hc3, AXI_OKAY);
      tok(1'b1, 0, UIED_ANS_DATA, 1'b0, {8'h12, 3'h0}, 12'd20);
      wr(OFS_FIRST_COUNT, 8'h05, AXI_OKAY);
      tok(1'b1, 0, UIED_ANS_DATA, 1'b0, 11'h090 + 11'd20, 12'd20);
      wr(OFS_CONFIG, 8'hdf, AXI_OKAY);
      tok(1'b0, 0, UIED_ANS_DATA, 1'b0, 11'h090 + 11'd40, 12'd160);
      wr(OFS_CONFIG, 8'hc0, AXI_OKAY);
      tok(1'b0, 0, UIED_ANS_DATA, 1'b0, 11'h090 + 11'd40, 12'd5);
      rd(OFS_IRQ_STATUS, 32'h01, AXI_OKAY, "iso status");
      wr(OFS_CONFIG, 8'h80, AXI_OKAY);
      tok(1'b1, 0, UIED_ANS_NAK, 1'b0, 11'h0, 12'h0);
      $display("test iso done");
      finish_test();
   end
endmodule : testbench
